// *** core/utcwm_pkg.sv ***
// Constants for the upstream traffic class window map
//
// Contract
// - Control bits 15:4 read zero, ignore writes
// - Control bits 3:1 hold writable class select
// - Window enable clear leaves class untouched
// - Window enable set tags in-range transactions
// - Lower bound register fully readable and writable
// - Upper bound register fully readable and writable
// - Disabled window bounds act as scratch storage
// - All registers read zero after reset
// - Offsets 1Ch, 20h-30h decode the registers
// - Global enable clear forces class zero
package utcwm_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_W1_UPPER = 8'h1C;
  localparam logic [7:0] OFS_W2_CTRL  = 8'h20;
  localparam logic [7:0] OFS_W2_LOWER = 8'h24;
  localparam logic [7:0] OFS_W2_UPPER = 8'h28;
  localparam logic [7:0] OFS_W3_CTRL  = 8'h2C;
  localparam logic [7:0] OFS_W3_LOWER = 8'h30;

  // ==========================================================
  // Control field layout
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_TC_LSB  = 1;
  localparam int CTRL_TC_MSB  = 3;
  localparam int CTRL_WIDTH   = 16;
  localparam int TC_WIDTH     = 3;

  // ==========================================================
  // Reset and default class values
  localparam logic [31:0]         BOUND_RESET = 32'h0000_0000;
  localparam logic [TC_WIDTH-1:0] TC_RESET    = 3'h0;
  localparam logic [TC_WIDTH-1:0] TC_DEFAULT  = 3'h0;

endpackage : utcwm_pkg

// *** core/utcwm_win_if.sv ***
// Carrier between the map core and one window comparator
`timescale 1ns/100ps
interface utcwm_win_if;
  logic        enable;
  logic [2:0]  tc;
  logic [31:0] lower;
  logic [31:0] upper;
  logic [31:0] addr;
  logic        hit;

  modport core (output enable, output tc, output lower, output upper, output addr, input hit);
  modport win  (input enable, input tc, input lower, input upper, input addr, output hit);
endinterface : utcwm_win_if

// *** core/utcwm_window.sv ***
// One address window comparator
`timescale 1ns/100ps
module utcwm_window (
  // Window configuration and address
  utcwm_win_if.win w
);

  logic in_range;

  always_comb begin
    in_range = (w.addr >= w.lower) && (w.addr <= w.upper);
    w.hit    = w.enable && in_range;
  end

endmodule // utcwm_window

// *** core/utcwm_map.sv ***
// Upstream traffic class window map: registers and class selection
`timescale 1ns/100ps
module utcwm_map (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Register access
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_hit,
  // Settings held by neighbouring register blocks
  input  wire logic        global_class_remap_enable,
  input  wire logic [15:0] w1_control,
  input  wire logic [31:0] w1_lower_bound,
  input  wire logic [31:0] w3_upper_bound,
  // Upstream transactions
  input  wire logic        txn_valid,
  input  wire logic [31:0] txn_addr,
  output logic             txn_tc_valid,
  output logic      [2:0]  txn_tc
);

  // ==========================================================
  // Register state
  logic [31:0] w1_upper_q, w1_upper_d;
  logic        w2_en_q,    w2_en_d;
  logic [2:0]  w2_tc_q,    w2_tc_d;
  logic [31:0] w2_lower_q, w2_lower_d;
  logic [31:0] w2_upper_q, w2_upper_d;
  logic        w3_en_q,    w3_en_d;
  logic [2:0]  w3_tc_q,    w3_tc_d;
  logic [31:0] w3_lower_q, w3_lower_d;
  logic [31:0] rdata_q,    rdata_d;
  logic        valid_q,    valid_d;
  logic [2:0]  tc_q,       tc_d;
  logic        dec_hit;

  always_comb begin
    w1_upper_d = w1_upper_q;
    w2_en_d    = w2_en_q;
    w2_tc_d    = w2_tc_q;
    w2_lower_d = w2_lower_q;
    w2_upper_d = w2_upper_q;
    w3_en_d    = w3_en_q;
    w3_tc_d    = w3_tc_q;
    w3_lower_d = w3_lower_q;
    rdata_d    = 32'h0000_0000;
    dec_hit    = 1'b1;
    unique case (reg_addr)
      utcwm_pkg::OFS_W1_UPPER: rdata_d = w1_upper_q;
      utcwm_pkg::OFS_W2_CTRL:  rdata_d = {28'h000_0000, w2_tc_q, w2_en_q};
      utcwm_pkg::OFS_W2_LOWER: rdata_d = w2_lower_q;
      utcwm_pkg::OFS_W2_UPPER: rdata_d = w2_upper_q;
      utcwm_pkg::OFS_W3_CTRL:  rdata_d = {28'h000_0000, w3_tc_q, w3_en_q};
      utcwm_pkg::OFS_W3_LOWER: rdata_d = w3_lower_q;
      default:                 dec_hit = 1'b0;
    endcase
    if (!reg_rd) begin
      rdata_d = 32'h0000_0000;
    end
    // Bounds store regardless of enable, so they double as scratch
    if (reg_wr) begin
      unique case (reg_addr)
        utcwm_pkg::OFS_W1_UPPER: w1_upper_d = reg_wdata;
        utcwm_pkg::OFS_W2_CTRL: begin
          w2_en_d = reg_wdata[utcwm_pkg::CTRL_EN_BIT];
          w2_tc_d = reg_wdata[utcwm_pkg::CTRL_TC_MSB:utcwm_pkg::CTRL_TC_LSB];
        end
        utcwm_pkg::OFS_W2_LOWER: w2_lower_d = reg_wdata;
        utcwm_pkg::OFS_W2_UPPER: w2_upper_d = reg_wdata;
        utcwm_pkg::OFS_W3_CTRL: begin
          w3_en_d = reg_wdata[utcwm_pkg::CTRL_EN_BIT];
          w3_tc_d = reg_wdata[utcwm_pkg::CTRL_TC_MSB:utcwm_pkg::CTRL_TC_LSB];
        end
        utcwm_pkg::OFS_W3_LOWER: w3_lower_d = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      w1_upper_q <= utcwm_pkg::BOUND_RESET;
      w2_en_q    <= 1'b0;
      w2_tc_q    <= utcwm_pkg::TC_RESET;
      w2_lower_q <= utcwm_pkg::BOUND_RESET;
      w2_upper_q <= utcwm_pkg::BOUND_RESET;
      w3_en_q    <= 1'b0;
      w3_tc_q    <= utcwm_pkg::TC_RESET;
      w3_lower_q <= utcwm_pkg::BOUND_RESET;
      rdata_q    <= 32'h0000_0000;
    end else begin
      w1_upper_q <= w1_upper_d;
      w2_en_q    <= w2_en_d;
      w2_tc_q    <= w2_tc_d;
      w2_lower_q <= w2_lower_d;
      w2_upper_q <= w2_upper_d;
      w3_en_q    <= w3_en_d;
      w3_tc_q    <= w3_tc_d;
      w3_lower_q <= w3_lower_d;
      rdata_q    <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_hit   = dec_hit;

  // ==========================================================
  // Window comparators
  utcwm_win_if win1 ();
  utcwm_win_if win2 ();
  utcwm_win_if win3 ();

  assign win1.enable = w1_control[utcwm_pkg::CTRL_EN_BIT];
  assign win1.tc     = w1_control[utcwm_pkg::CTRL_TC_MSB:utcwm_pkg::CTRL_TC_LSB];
  assign win1.lower  = w1_lower_bound;
  assign win1.upper  = w1_upper_q;
  assign win1.addr   = txn_addr;
  assign win2.enable = w2_en_q;
  assign win2.tc     = w2_tc_q;
  assign win2.lower  = w2_lower_q;
  assign win2.upper  = w2_upper_q;
  assign win2.addr   = txn_addr;
  assign win3.enable = w3_en_q;
  assign win3.tc     = w3_tc_q;
  assign win3.lower  = w3_lower_q;
  assign win3.upper  = w3_upper_bound;
  assign win3.addr   = txn_addr;

  utcwm_window u_win1 (.w(win1));
  utcwm_window u_win2 (.w(win2));
  utcwm_window u_win3 (.w(win3));

  // ==========================================================
  // Class selection
  // Overlapping windows: lowest numbered window wins
  always_comb begin
    valid_d = txn_valid;
    tc_d    = utcwm_pkg::TC_DEFAULT;
    if (!txn_valid) begin
      tc_d = utcwm_pkg::TC_DEFAULT;
    end else if (!global_class_remap_enable) begin
      tc_d = utcwm_pkg::TC_DEFAULT;
    end else if (win1.hit) begin
      tc_d = win1.tc;
    end else if (win2.hit) begin
      tc_d = win2.tc;
    end else if (win3.hit) begin
      tc_d = win3.tc;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      tc_q    <= utcwm_pkg::TC_RESET;
    end else begin
      valid_q <= valid_d;
      tc_q    <= tc_d;
    end
  end

  assign txn_tc_valid = valid_q;
  assign txn_tc       = tc_q;

endmodule // utcwm_map

// *** tb/utcwm_txn_src.sv ***
// Upstream bus master model feeding transaction addresses
`timescale 1ns/100ps
module utcwm_txn_src (
  // Bench request
  input  wire logic        clock,
  input  wire logic        go,
  input  wire logic [31:0] addr,
  // Transaction side
  output logic             txn_valid,
  output logic      [31:0] txn_addr
);
  logic [31:0] last_q = 32'h0;
  always_ff @(posedge clock) if (go) last_q <= addr;
  assign txn_valid = go;
  // Idle address inverted so a stale match never passes
  assign txn_addr = go ? addr : ~last_q;
endmodule // utcwm_txn_src

// *** tb/utcwm_map_asserts.sv ***
// Port checker for the window map
`timescale 1ns/100ps
module utcwm_map_asserts (
  // Watched ports
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_hit,
  input wire logic        global_class_remap_enable,
  input wire logic        txn_valid,
  input wire logic        txn_tc_valid,
  input wire logic [2:0]  txn_tc
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ======
  // Storage, decode, class
  // Write, one idle cycle, then read back, as the bench tasks pace it
  property p_rw(o, m);
    reg_wr && !reg_rd && reg_addr == o ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == o
      |=> reg_rdata == ($past(reg_wdata, 3) & m);
  endproperty
  a_w1_upper_rw: assert property (p_rw(8'h1C, 32'hFFFFFFFF)) else $error("w1 hi");
  a_w2_lower_rw: assert property (p_rw(8'h24, 32'hFFFFFFFF)) else $error("w2 lo");
  a_w2_upper_rw: assert property (p_rw(8'h28, 32'hFFFFFFFF)) else $error("w2 hi");
  a_w3_lower_rw: assert property (p_rw(8'h30, 32'hFFFFFFFF)) else $error("w3 lo");
  a_w2_ctrl_rw: assert property (p_rw(8'h20, 32'hF)) else $error("w2 ctrl");
  a_w3_ctrl_rw: assert property (p_rw(8'h2C, 32'hF)) else $error("w3 ctrl");
  a_decode_hit: assert property
    (reg_hit == (reg_addr inside {8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30})) else $error("hit");
  a_global_off_zero: assert property
    (txn_valid && !global_class_remap_enable |=> txn_tc_valid && txn_tc == 3'h0) else $error("tc");
  cover property (txn_tc_valid && txn_tc != 3'h0);
  cover property (reg_rd && !reg_hit);
  cover property (txn_valid && !global_class_remap_enable);
endmodule // utcwm_map_asserts
bind utcwm_map utcwm_map_asserts utcwm_map_asserts_i (.clock, .rst_n, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .reg_hit, .global_class_remap_enable, .txn_valid,
  .txn_tc_valid, .txn_tc);

// *** tb/tb_utcwm_map.sv ***
// Self-checking bench for the window map
`timescale 1ns/100ps
module tb_utcwm_map;
  localparam logic [7:0] OFS [6] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30};
  logic        clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, glob = 1'b0;
  logic        go = 1'b0, reg_hit, txn_valid, txn_tc_valid;
  logic [7:0]  reg_addr = 8'h00, w;
  logic [31:0] reg_wdata = 32'h0, a_in = 32'h0, reg_rdata, txn_addr, b, d;
  logic [31:0] sh [64] = '{default: 32'h0};
  logic [31:0] pt [5];
  logic [2:0]  txn_tc;
  integer      seed = 32'h3C79;
  int          errors = 0, num_checks = 0;
  always #10 clock = ~clock;
  utcwm_txn_src utcwm_txn_src_i (.clock, .go, .addr(a_in), .txn_valid, .txn_addr);
  utcwm_map utcwm_map_i (.clock, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_hit, .global_class_remap_enable(glob), .w1_control(sh[8'h14][15:0]),
    .w1_lower_bound(sh[8'h18]), .w3_upper_bound(sh[8'h34]), .txn_valid, .txn_addr,
    .txn_tc_valid, .txn_tc);
  // ======
  // Shadow layout: window n at 14h+12n (ctrl, lower, upper)
  function automatic logic [31:0] mask(logic [7:0] a);
    return (a == 8'h20 || a == 8'h2C) ? 32'hF : 32'hFFFFFFFF;
  endfunction
  function automatic logic [2:0] tc_of(logic [31:0] a);
    tc_of = 3'h0;
    for (int n = 2; n >= 0; n--)
      if (glob && sh[20 + 12 * n][0] && a >= sh[24 + 12 * n] && a <= sh[28 + 12 * n])
        tc_of = sh[20 + 12 * n][3:1];
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(negedge clock);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
    @(negedge clock);
    reg_wr = 1'b0;
    if (a inside {OFS}) sh[a] = v & mask(a);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(negedge clock);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge clock);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
    chk({31'h0, reg_hit}, {31'h0, (a inside {OFS})});
  endtask
  task automatic send(logic [31:0] a);
    logic [2:0] e;
    e = tc_of(a);
    @(negedge clock);
    {go, a_in} = {1'b1, a};
    @(negedge clock);
    go = 1'b0;
    chk({28'h0, txn_tc_valid, txn_tc}, {28'h0, 1'b1, e});
  endtask
  initial begin
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    foreach (OFS[j]) rd(OFS[j], 32'h0);
    for (int i = 0; i < 40; i++) begin
      b = $random(seed);
      glob = ($random(seed) & 3) != 0;
      sh[8'h14] = $random(seed) & 32'hF;
      sh[8'h18] = b + ($random(seed) & 32'h3F);
      sh[8'h34] = b + ($random(seed) & 32'h3F);
      foreach (OFS[j]) begin
        d = (mask(OFS[j]) == 32'hF) ? $random(seed) : b + ($random(seed) & 32'h3F);
        wr(OFS[j], d);
        rd(OFS[j], d & mask(OFS[j]));
      end
      // Window 1 control lives in a neighbour block
      wr(8'h14, b);
      rd(8'h14, 32'h0);
      w = 8'(20 + 12 * ({$random(seed)} % 3));
      pt = '{sh[w + 4] - 1, sh[w + 4], sh[w + 8], sh[w + 8] + 1, b};
      foreach (pt[p]) send(pt[p]);
    end
    // Mid-run reset must bring every local register back to zero
    @(negedge clock) rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    foreach (OFS[j]) begin
      sh[OFS[j]] = 32'h0;
      rd(OFS[j], 32'h0);
    end
    send(sh[8'h18]);
    stop_test;
  end
  initial begin
    repeat (4000) @(posedge clock);
    errors++;
    stop_test;
  end
endmodule // tb_utcwm_map
